// >>> verilog/dcf_fifo.v
// FIFO core: pointers, offset loading, status flags and output port.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defs.vh"

module dcf_fifo #(
  parameter DEPTH = `DCF_DEPTH,
  parameter AW    = `DCF_ADDR_W,
  parameter DW    = `DCF_DATA_W
) (
  // Clock and reset.
  input  wire          clk,
  input  wire          rst_n,
  // Write side.
  input  wire          wrEn1N,
  input  wire          wrEn2OrLoad,
  input  wire [DW-1:0] wrData,
  // Read side.
  input  wire          rdEnN,
  input  wire          outDriveEn,
  output wire [DW-1:0] rdData,
  output reg           rdDataOe,
  // Status flags, all active low.
  output reg           emptyFlagN,
  output reg           fullFlagN,
  output reg           almostEmptyN,
  output reg           almostFullN,
  // Strapped mode, high when the pin acts as second write enable.
  output reg           secondEnMode
);

  // Word count between two pointers that carry one wrap bit.
  function [AW:0] ptrDiff;
    input [AW:0] a;
    input [AW:0] b;
    begin
      ptrDiff = a - b;
    end
  endfunction

  // Constants are widened to a full word first, then cut to the pointer width on purpose.
  localparam [31:0] DEPTH_32      = DEPTH;
  localparam [AW:0] DEPTH_W       = DEPTH_32[AW:0];
  localparam [31:0] OFFSET_RST_32 = {18'h00000, `DCF_OFFSET_RST};

  reg  [AW:0]   wrPtr_q;       // Write pointer.
  reg  [AW:0]   memRdPtr_q;    // Next address prefetched from the array.
  reg  [AW:0]   popPtr_q;      // Words handed to the reader so far.
  reg  [AW:0]   popPtrW_q;     // Pop pointer as the write side sees it.
  reg  [AW:0]   wrPtrR_q;      // Write pointer as the read side sees it.
  reg           inFlight_q;    // Array read issued, data arrives next cycle.
  reg  [AW-1:0] aeOffset_q;    // Almost-empty offset n.
  reg  [AW-1:0] afOffset_q;    // Almost-full offset m.
  reg  [1:0]    loadStep_q;    // Which offset half the next load writes.
  reg  [AW:0]   wrCnt_d;       // Write-side count after this edge.
  reg  [AW:0]   rdCnt_d;       // Read-side count after this edge.

  wire          bufInReady;
  wire          bufOutValid;
  wire [DW-1:0] memRdData;

  // Load mode: pin low with wrEn1N low writes an offset instead of data.
  wire loadCycle = !secondEnMode && !wrEn1N && !wrEn2OrLoad;
  wire wrReq     = !wrEn1N && wrEn2OrLoad;
  wire wrDo      = wrReq && fullFlagN;
  // A read pops only while empty is released, so the word is already there.
  wire rdDo      = !rdEnN && emptyFlagN && bufOutValid;
  // Prefetch one word when the buffer can take it and no array read is in flight.
  wire issue     = !inFlight_q && bufInReady && (wrPtrR_q != memRdPtr_q);
  // Buffer holds a word after this edge: a push lands, or a word survives the pop.
  // At most one array read is in flight, so a landing push always finds room.
  wire bufNextValid = inFlight_q || (bufOutValid && !(rdDo && bufInReady));

  // Strap capture and the pointer registers; clocks may run throughout reset.
  always @(posedge clk) begin
    if (!rst_n) begin
      secondEnMode <= wrEn2OrLoad;
      wrPtr_q      <= {(AW+1){1'b0}};
      memRdPtr_q   <= {(AW+1){1'b0}};
      popPtr_q     <= {(AW+1){1'b0}};
      popPtrW_q    <= {(AW+1){1'b0}};
      wrPtrR_q     <= {(AW+1){1'b0}};
      inFlight_q   <= 1'b0;
    end else begin
      if (wrDo) begin
        wrPtr_q <= wrPtr_q + {{AW{1'b0}}, 1'b1};
      end
      if (issue) begin
        memRdPtr_q <= memRdPtr_q + {{AW{1'b0}}, 1'b1};
      end
      if (rdDo) begin
        popPtr_q <= popPtr_q + {{AW{1'b0}}, 1'b1};
      end
      // One register stage models the clock-to-clock skew window.
      popPtrW_q  <= popPtr_q;
      wrPtrR_q   <= wrPtr_q;
      inFlight_q <= issue;
    end
  end

  // Offset registers: four loads give n low, n high, m low, m high.
  always @(posedge clk) begin
    if (!rst_n) begin
      aeOffset_q <= OFFSET_RST_32[AW-1:0];
      afOffset_q <= OFFSET_RST_32[AW-1:0];
      loadStep_q <= 2'h0;
    end else if (loadCycle) begin
      case (loadStep_q)
        2'h0: begin
          aeOffset_q <= {aeOffset_q[AW-1:DW], wrData};
        end
        2'h1: begin
          aeOffset_q <= {wrData[AW-DW-1:0], aeOffset_q[DW-1:0]};
        end
        2'h2: begin
          afOffset_q <= {afOffset_q[AW-1:DW], wrData};
        end
        default: begin
          afOffset_q <= {wrData[AW-DW-1:0], afOffset_q[DW-1:0]};
        end
      endcase
      loadStep_q <= loadStep_q + 2'h1;
    end
  end

  // Counts after this edge, each side with the other's delayed pointer.
  always @* begin
    wrCnt_d = ptrDiff(wrDo ? wrPtr_q + {{AW{1'b0}}, 1'b1} : wrPtr_q, popPtrW_q);
    rdCnt_d = ptrDiff(wrPtrR_q, rdDo ? popPtr_q + {{AW{1'b0}}, 1'b1} : popPtr_q);
  end

  // Flags change only on edges; a flag holds at least one cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      emptyFlagN   <= 1'b0;
      almostEmptyN <= 1'b0;
      fullFlagN    <= 1'b1;
      almostFullN  <= 1'b1;
    end else begin
      // Full releases on the first write edge that sees the read.
      fullFlagN    <= (wrCnt_d != DEPTH_W);
      // Low from depth minus m words upward; the write that lowers it
      // leaves full minus m words held, so m words are still free.
      almostFullN  <= (wrCnt_d < DEPTH_W - {1'b0, afOffset_q});
      // Empty follows the buffer one edge late, so the word waits at the
      // port before the flag rises; latency arises whenever the buffer runs dry.
      // It falls on the pop that drains the buffer, because the prefetch
      // refills at half rate and a high flag must always have a word behind it.
      emptyFlagN   <= bufOutValid && bufNextValid;
      // Low at n words or fewer, through this single register stage.
      almostEmptyN <= (rdCnt_d > {1'b0, aeOffset_q});
    end
  end

  // Output enable register: drive when outDriveEn is low.
  always @(posedge clk) begin
    if (!rst_n) begin
      rdDataOe <= !outDriveEn;
    end else begin
      rdDataOe <= !outDriveEn;
    end
  end

  // Storage array.
  dcf_mem #(
    .AW (AW),
    .DW (DW)
  ) uMem (
    .clk    (clk),
    .wrEn   (wrDo),
    .wrAddr (wrPtr_q[AW-1:0]),
    .wrData (wrData),
    .rdEn   (issue),
    .rdAddr (memRdPtr_q[AW-1:0]),
    .rdData (memRdData)
  );

  // The buffer head is the output register; it resets to zero, so the
  // port reads low after reset until the first word arrives.
  dcf_buf #(
    .DW (DW)
  ) uBuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (inFlight_q),
    .inReady  (bufInReady),
    .inData   (memRdData),
    .outValid (bufOutValid),
    .outReady (rdDo),
    .outData  (rdData)
  );

endmodule // dcf_fifo

`default_nettype wire

// >>> pkg/dcf_defs.vh
// Constants for the two-port nine-bit FIFO with status flags.
// Functional notes
// - Level on wrEn2OrLoad at reset picks its role.
// - After reset, data low if driven, else released.
// - Reset works with both clocks still running.
// - First word readable cycle after empty releases.
// - Full releases on write edge after read.
// - Empty releases on read edge after write.
// - Almost-empty moves on read edge after skew.
// - Almost-full moves on write edge after skew.
// - Almost-full threshold is depth minus offset m.
// - Almost-full falls holding full minus m.
// - Almost-empty falls holding empty plus n.
// - Extra first-read latency only leaving empty state; code also adds it whenever reads drain the buffer.
// - Almost-empty registered once, low at n or fewer.
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

`define DCF_DATA_W       9
`define DCF_DEPTH        16384
`define DCF_ADDR_W       14
`define DCF_OFFSET_RST   14'h0007
`define DCF_CLK_NS       20
`define DCF_SKEW1_NS     5
`define DCF_SKEW2_NS     15
`define DCF_SKEW1_CYC    ((`DCF_SKEW1_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_SKEW2_CYC    ((`DCF_SKEW2_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_LOAD_STEPS   4

`endif

// >>> verilog/dcf_mem.v
// Storage array with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none

module dcf_mem #(
  parameter AW = 14,
  parameter DW = 9
) (
  // Clock.
  input  wire          clk,
  // Write port.
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  // Read port.
  input  wire          rdEn,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  // The array itself; no reset, its contents are undefined until written.
  reg [DW-1:0] store [0:(1<<AW)-1];

  // Writes land on the clock edge.
  always @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // Read data comes out of a register one cycle after the request.
  always @(posedge clk) begin
    if (rdEn) begin
      rdData <= store[rdAddr];
    end
  end

endmodule // dcf_mem

`default_nettype wire

// >>> verilog/dcf_buf.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module dcf_buf #(
  parameter DW = 9
) (
  // Clock and reset.
  input  wire          clk,
  input  wire          rst_n,
  // Filling side.
  input  wire          inValid,
  output wire          inReady,
  input  wire [DW-1:0] inData,
  // Draining side.
  output wire          outValid,
  input  wire          outReady,
  output wire [DW-1:0] outData
);

  reg [DW-1:0] head_q;   // Word shown at the output.
  reg [DW-1:0] tail_q;   // Second word, waits behind the head.
  reg [1:0]    count_q;  // Number of words held, 0 to 2.

  wire push = inValid & inReady;
  wire pop  = outValid & outReady;

  // Ready only while a slot is free, so a stalled reader backs up the source.
  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = head_q;

  // Head refills from the tail on a pop; new words go to the first free slot.
  always @(posedge clk) begin
    if (!rst_n) begin
      head_q  <= {DW{1'b0}};
      tail_q  <= {DW{1'b0}};
      count_q <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_q == 2'h0) begin
            head_q <= inData;
          end else begin
            tail_q <= inData;
          end
          count_q <= count_q + 2'h1;
        end
        2'b01: begin
          head_q  <= tail_q;
          count_q <= count_q - 2'h1;
        end
        2'b11: begin
          // Count stays; with one held, the new word becomes head.
          if (count_q == 2'h1) begin
            head_q <= inData;
          end else begin
            head_q <= tail_q;
            tail_q <= inData;
          end
        end
        default: begin
          head_q <= head_q;
        end
      endcase
    end
  end

endmodule // dcf_buf

`default_nettype wire

// >>> dv/dcf_fifo_monitor.sv
// Checker of the port timing of the FIFO core.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_mon #(
  parameter DW = 9
) (
  // Clock and reset.
  input wire          clk,
  input wire          rst_n,
  // Requests.
  input wire          wrEn1N,
  input wire          wrEn2OrLoad,
  input wire          rdEnN,
  input wire          outDriveEn,
  // Results.
  input wire [DW-1:0] rdData,
  input wire          rdDataOe,
  input wire          emptyFlagN,
  input wire          fullFlagN,
  input wire          almostEmptyN,
  input wire          almostFullN,
  input wire          secondEnMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write taken while the FIFO still shows empty.
  sequence wrEmpty;
    !emptyFlagN && !wrEn1N && wrEn2OrLoad && fullFlagN;
  endsequence
  // A read taken while full, then the writer stays idle.
  sequence popFull;
    !fullFlagN && !rdEnN && emptyFlagN ##1 wrEn1N [*3];
  endsequence
  oe_follow_a: assert property (rdDataOe == !$past(outDriveEn))
    else $error("output enable wrong");
  reset_flags_a: assert property ($rose(rst_n) |->
    !emptyFlagN && !almostEmptyN && fullFlagN && almostFullN && rdData == 0)
    else $error("flags wrong after reset");
  strap_mode_a: assert property ($rose(rst_n) |-> secondEnMode == $past(wrEn2OrLoad))
    else $error("strap mode wrong");
  empty_release_a: assert property (wrEmpty |-> ##[1:5] emptyFlagN)
    else $error("empty flag late");
  first_word_a: assert property ($rose(emptyFlagN) |-> $stable(rdData))
    else $error("first word not ready");
  full_release_a: assert property (popFull |=> fullFlagN)
    else $error("full flag late");
  full_hold_a: assert property (rdEnN [*4] ##0 !fullFlagN |=> !fullFlagN)
    else $error("full flag released");
  almost_split_a: assert property (!almostFullN |-> almostEmptyN)
    else $error("almost flags both low");
  full_almost_a: assert property (!fullFlagN |-> !almostFullN)
    else $error("almost full high while full");
endmodule // dcf_fifo_mon
bind dcf_fifo dcf_fifo_mon #(.DW(DW)) u_mon (.clk, .rst_n, .wrEn1N, .wrEn2OrLoad,
  .rdEnN, .outDriveEn, .rdData, .rdDataOe, .emptyFlagN, .fullFlagN, .almostEmptyN,
  .almostFullN, .secondEnMode);
`default_nettype wire

// >>> dv/dcf_reader.sv
// Reader model that pops words and checks their order.
`timescale 1ns/1ps
`default_nettype none
module dcf_reader (
  // Clock and control.
  input  wire       clk,
  input  wire       drainEn,
  // FIFO read side.
  input  wire       emptyFlagN,
  input  wire [8:0] rdData,
  output reg        rdEnN,
  // Results.
  output reg  [8:0] popCnt,
  output reg  [8:0] badCnt
);
  initial begin
    rdEnN = 1'b1;
    popCnt = 9'h000;
    badCnt = 9'h000;
  end
  // The enable moves only at the falling edge, so a stall is never torn.
  always @(negedge clk) begin
    rdEnN <= ~drainEn;
  end
  // Words were written as a count, so every pop must match it.
  always @(posedge clk) begin
    if (!rdEnN && emptyFlagN) begin
      if (rdData !== popCnt) badCnt <= badCnt + 9'h001;
      popCnt <= popCnt + 9'h001;
    end
  end
endmodule // dcf_reader
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the FIFO core with a reader model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam DEPTH = 64; // Small depth keeps the fill short.
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        wrEn1N = 1'b1;
  reg        wrEn2OrLoad = 1'b1;
  reg  [8:0] wrData = 9'h000;
  reg        outDriveEn = 1'b0;
  reg        drainEn = 1'b0;
  wire       rdEnN, rdDataOe, emptyFlagN, fullFlagN;
  wire       almostEmptyN, almostFullN, secondEnMode;
  wire [8:0] rdData, popCnt, badCnt;
  integer    error_cnt = 0;
  integer    total_checks = 0;
  integer    i;
  always #10 clk = ~clk;
  // The offset halves need an address wider than the data, so the array is
  // larger than the depth; the count logic still stops at DEPTH words.
  dcf_fifo #(.DEPTH(DEPTH), .AW(10), .DW(9)) dut (.clk(clk), .rst_n(rst_n),
    .wrEn1N(wrEn1N), .wrEn2OrLoad(wrEn2OrLoad), .wrData(wrData), .rdEnN(rdEnN),
    .outDriveEn(outDriveEn), .rdData(rdData), .rdDataOe(rdDataOe),
    .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .almostEmptyN(almostEmptyN),
    .almostFullN(almostFullN), .secondEnMode(secondEnMode));
  dcf_reader rdr (.clk(clk), .drainEn(drainEn), .emptyFlagN(emptyFlagN),
    .rdData(rdData), .rdEnN(rdEnN), .popCnt(popCnt), .badCnt(badCnt));
  // Compare one value and count it.
  task chk(input [8:0] got, input [8:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Reset with a strap level; clocks keep running throughout.
  task rst(input md, input od);
    begin
      rst_n = 1'b0;
      wrEn2OrLoad = md;
      outDriveEn = od;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      wrEn2OrLoad = 1'b1;
      @(negedge clk);
    end
  endtask
  // One write or offset load, then an idle cycle so no signal flips twice.
  task wr(input [8:0] d, input ld);
    begin
      wrData = d;
      wrEn2OrLoad = ~ld;
      wrEn1N = 1'b0;
      @(negedge clk);
      wrEn1N = 1'b1;
      wrEn2OrLoad = 1'b1;
      @(negedge clk);
    end
  endtask
  task final_report;
    begin
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog well beyond the roughly 560 cycles the tests need.
  initial begin
    #(3000 * 20);
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    @(negedge clk);
    rst(1'b1, 1'b1);
    chk(secondEnMode, 1'b1);
    chk(rdDataOe, 1'b0);
    chk(rdData, 9'h000);
    chk({fullFlagN, almostFullN, emptyFlagN, almostEmptyN}, 4'hc);
    outDriveEn = 1'b0;
    @(negedge clk);
    chk(rdDataOe, 1'b1);
    // Fill with the reader stalled; probe the threshold on both sides.
    for (i = 0; i < DEPTH; i = i + 1) begin
      wr(i[8:0], 1'b0);
      if (i == DEPTH - 9 || i == DEPTH - 8) begin
        repeat (4) @(negedge clk);
        chk(almostFullN, i == DEPTH - 9);
      end
    end
    repeat (4) @(negedge clk);
    chk({fullFlagN, almostEmptyN}, 2'h1);
    wr(9'h1ff, 1'b0); // A write into a full FIFO must be dropped.
    drainEn = 1'b1;
    repeat (6 * DEPTH) @(negedge clk);
    drainEn = 1'b0;
    chk(popCnt, 9'h040);
    chk(badCnt, 9'h000);
    chk({fullFlagN, emptyFlagN, almostEmptyN}, 3'h4);
    // A single word into the empty FIFO.
    wr(9'h1a5, 1'b0);
    for (i = 0; i < 10 && emptyFlagN !== 1'b1; i = i + 1) @(negedge clk);
    chk(emptyFlagN, 1'b1);
    chk(rdData, 9'h1a5);
    // Load mode: set the almost-empty offset to two, then hold three words.
    rst(1'b0, 1'b0);
    chk(secondEnMode, 1'b0);
    wr(9'h002, 1'b1);
    wr(9'h000, 1'b1);
    wr(9'h007, 1'b1);
    wr(9'h000, 1'b1);
    for (i = 0; i < 3; i = i + 1) wr(i[8:0], 1'b0);
    repeat (8) @(negedge clk);
    chk(almostEmptyN, 1'b1);
    final_report;
  end
endmodule // tb
`default_nettype wire
